// [shared/idx_seq_pkg.sv]
// Package: constants and types for the indexed 8-bit offset cycle sequencer
`default_nettype none
package idx_seq_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;

  // ----------------------------------------
  // Cycle counts per class, and the number of the first cycle
  // ----------------------------------------
  localparam logic [2:0] CYC_READ = 3'h4;
  localparam logic [2:0] CYC_STORE = 3'h5;
  localparam logic [2:0] CYC_TEST = 3'h5;
  localparam logic [2:0] CYC_RMW = 3'h6;
  localparam logic [2:0] CYC_CALL = 3'h6;
  localparam logic [2:0] CYC_FIRST = 3'h1;

  // Direction strobe levels
  localparam logic DIR_READ = 1'b1;
  localparam logic DIR_WRITE = 1'b0;

  // Reset values
  localparam logic [ADDR_W-1:0] ADDR_RST = 13'h0000;
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

  // ----------------------------------------
  // Instruction classes
  // ----------------------------------------
  typedef enum logic [2:0] {
    CLS_READ = 3'h0,   // add, adc, and, bit, cmp, compare_index_op, eor,
                       // load_accumulator_op, load_index_op, ora, sbc, sub
    CLS_STORE = 3'h1,  // store_accumulator_op, store_index_op
    CLS_TEST = 3'h2,   // test_operand_op
    CLS_RMW = 3'h3,    // shifts, rotates, clr, com, dec, inc, neg
    CLS_CALL = 3'h4    // call_subroutine_op
  } op_class_t;

  typedef enum logic [2:0] {
    ADR_OPCODE = 3'h0,
    ADR_OPCODE_P1 = 3'h1,
    ADR_OPCODE_P2 = 3'h2,
    ADR_EFFECTIVE = 3'h3,
    ADR_STACK = 3'h4,
    ADR_STACK_M1 = 3'h5
  } addr_src_t;

  // Start request from the decoder
  typedef struct packed {
    op_class_t op_class;
    logic [ADDR_W-1:0] opcode_addr;
    logic [DATA_W-1:0] index;
    logic [ADDR_W-1:0] stack_ptr;
    logic [DATA_W-1:0] new_data;
  } seq_req_t;

  // Bus cycle presented to memory and peripherals
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic dir;
    logic [DATA_W-1:0] wdata;
    addr_src_t src;
  } bus_cycle_t;

endpackage

`default_nettype wire

// [rtl/idx_offset_seq.sv]
// Bus-cycle sequencer for indexed addressing with an 8-bit offset
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Read class: four cycles, operand read fourth
// - Stores: five cycles, write at index+offset
// - Test: five cycles, next opcode fifth
// - Read-modify-write: six cycles, write sixth
// - Call: six cycles, subroutine opcode fourth
// - Call writes return low, then high
// - Cycle one always reads the opcode
module idx_offset_seq #(
  parameter int ADDR_W = idx_seq_pkg::ADDR_W,
  parameter int DATA_W = idx_seq_pkg::DATA_W
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire idx_seq_pkg::seq_req_t req_in,
  input wire logic [DATA_W-1:0] rdata_in,
  output logic busy_out,
  output logic done_out,
  output idx_seq_pkg::bus_cycle_t bus_out,
  output logic [2:0] cycle_out,
  output logic [DATA_W-1:0] operand_out
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // The carrier structs fix both widths, so other values cannot be served
  if (ADDR_W != idx_seq_pkg::ADDR_W || DATA_W != idx_seq_pkg::DATA_W) begin : g_chk
    $error("idx_offset_seq: widths must match the package carrier");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } state_t;

  state_t state_q, state_d;
  logic [2:0] cyc_q, cyc_d;
  idx_seq_pkg::seq_req_t req_q, req_d;
  logic [DATA_W-1:0] offset_q, offset_d;
  logic [DATA_W-1:0] operand_q, operand_d;
  logic [ADDR_W-1:0] ea_q, ea_d;
  idx_seq_pkg::bus_cycle_t bus_q, bus_d;
  logic done_q, done_d;

  function automatic logic [2:0] class_len(input idx_seq_pkg::op_class_t c);
    case (c)
      idx_seq_pkg::CLS_READ: class_len = idx_seq_pkg::CYC_READ;
      idx_seq_pkg::CLS_STORE: class_len = idx_seq_pkg::CYC_STORE;
      idx_seq_pkg::CLS_TEST: class_len = idx_seq_pkg::CYC_TEST;
      idx_seq_pkg::CLS_RMW: class_len = idx_seq_pkg::CYC_RMW;
      idx_seq_pkg::CLS_CALL: class_len = idx_seq_pkg::CYC_CALL;
      default: class_len = idx_seq_pkg::CYC_READ;
    endcase
  endfunction

  // Zero-extended sum so that a carry out of the low byte reaches the next page
  function automatic logic [ADDR_W-1:0] eff_addr(input logic [DATA_W-1:0] x,
                                                 input logic [DATA_W-1:0] off);
    eff_addr = ADDR_W'({1'b0, x} + {1'b0, off});
  endfunction

  // Address source for a given class and cycle number
  function automatic idx_seq_pkg::addr_src_t pick_src(input idx_seq_pkg::op_class_t c,
                                                      input logic [2:0] n);
    pick_src = idx_seq_pkg::ADR_OPCODE_P1;
    if (n == 3'h1) begin
      pick_src = idx_seq_pkg::ADR_OPCODE;
    end else if (n == 3'h4) begin
      // Stores keep the offset address on the bus one cycle longer
      pick_src = (c == idx_seq_pkg::CLS_STORE) ? idx_seq_pkg::ADR_OPCODE_P1
                                               : idx_seq_pkg::ADR_EFFECTIVE;
    end else if (n == 3'h5) begin
      case (c)
        idx_seq_pkg::CLS_STORE: pick_src = idx_seq_pkg::ADR_EFFECTIVE;
        idx_seq_pkg::CLS_TEST: pick_src = idx_seq_pkg::ADR_OPCODE_P2;
        idx_seq_pkg::CLS_CALL: pick_src = idx_seq_pkg::ADR_STACK;
        default: pick_src = idx_seq_pkg::ADR_EFFECTIVE;
      endcase
    end else if (n == 3'h6) begin
      pick_src = (c == idx_seq_pkg::CLS_CALL) ? idx_seq_pkg::ADR_STACK_M1
                                              : idx_seq_pkg::ADR_EFFECTIVE;
    end
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    logic [ADDR_W-1:0] ret;
    logic [2:0] n;
    idx_seq_pkg::addr_src_t src;
    ret = '0;
    n = '0;
    src = idx_seq_pkg::ADR_OPCODE;
    state_d = state_q;
    cyc_d = cyc_q;
    req_d = req_q;
    offset_d = offset_q;
    operand_d = operand_q;
    ea_d = ea_q;
    bus_d = bus_q;
    done_d = 1'b0;
    // Return address points past the two instruction bytes
    ret = ADDR_W'(req_q.opcode_addr + ADDR_W'(2));
    case (state_q)
      ST_IDLE: begin
        if (start_in) begin
          req_d = req_in;
          state_d = ST_RUN;
          cyc_d = idx_seq_pkg::CYC_FIRST;
          bus_d.addr = req_in.opcode_addr;
          bus_d.dir = idx_seq_pkg::DIR_READ;
          bus_d.wdata = idx_seq_pkg::DATA_RST;
          bus_d.src = idx_seq_pkg::ADR_OPCODE;
        end
      end
      ST_RUN: begin
        // A request while busy is dropped unseen; the requester waits for done
        // Offset byte arrives on the read in cycle 2
        if (cyc_q == 3'h2) begin
          offset_d = rdata_in;
        end
        // Offset is latched before cycle 3, so the sum is ready for cycle 4
        if (cyc_q == 3'h3) begin
          ea_d = eff_addr(req_q.index, offset_q);
        end
        if (cyc_q == 3'h4 && req_q.op_class != idx_seq_pkg::CLS_STORE) begin
          operand_d = rdata_in;
        end
        if (cyc_q == class_len(req_q.op_class)) begin
          // Strobe back to read so no write lingers past the last cycle
          state_d = ST_IDLE;
          cyc_d = 3'h0;
          done_d = 1'b1;
          bus_d.dir = idx_seq_pkg::DIR_READ;
          bus_d.wdata = idx_seq_pkg::DATA_RST;
        end else begin
          n = 3'(cyc_q + 3'h1);
          cyc_d = n;
          src = pick_src(req_q.op_class, n);
          bus_d.src = src;
          bus_d.dir = idx_seq_pkg::DIR_READ;
          bus_d.wdata = idx_seq_pkg::DATA_RST;
          case (src)
            idx_seq_pkg::ADR_OPCODE_P1: bus_d.addr = ADDR_W'(req_q.opcode_addr + ADDR_W'(1));
            idx_seq_pkg::ADR_OPCODE_P2: bus_d.addr = ret;
            idx_seq_pkg::ADR_EFFECTIVE: begin
              bus_d.addr = (n == 3'h4) ? eff_addr(req_q.index, offset_q)
                                       : ea_q;
              if (n == class_len(req_q.op_class) &&
                  (req_q.op_class == idx_seq_pkg::CLS_STORE ||
                   req_q.op_class == idx_seq_pkg::CLS_RMW)) begin
                bus_d.dir = idx_seq_pkg::DIR_WRITE;
                bus_d.wdata = req_q.new_data;
              end
            end
            // Return low byte goes first, to the higher stack slot
            idx_seq_pkg::ADR_STACK: begin
              bus_d.addr = req_q.stack_ptr;
              bus_d.dir = idx_seq_pkg::DIR_WRITE;
              bus_d.wdata = ret[DATA_W-1:0];
            end
            idx_seq_pkg::ADR_STACK_M1: begin
              bus_d.addr = ADDR_W'(req_q.stack_ptr - ADDR_W'(1));
              bus_d.dir = idx_seq_pkg::DIR_WRITE;
              bus_d.wdata = DATA_W'(ret >> DATA_W);
            end
            default: bus_d.addr = req_q.opcode_addr;
          endcase
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
      cyc_q <= 3'h0;
      req_q <= '0;
      offset_q <= idx_seq_pkg::DATA_RST;
      operand_q <= idx_seq_pkg::DATA_RST;
      ea_q <= idx_seq_pkg::ADDR_RST;
      bus_q <= '{addr: idx_seq_pkg::ADDR_RST, dir: idx_seq_pkg::DIR_READ,
                 wdata: idx_seq_pkg::DATA_RST, src: idx_seq_pkg::ADR_OPCODE};
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cyc_q <= cyc_d;
      req_q <= req_d;
      offset_q <= offset_d;
      operand_q <= operand_d;
      ea_q <= ea_d;
      bus_q <= bus_d;
      done_q <= done_d;
    end
  end

  assign busy_out = (state_q == ST_RUN);
  assign done_out = done_q;
  assign bus_out = bus_q;
  // Cycle count is cleared in the done cycle, so it reads zero when idle
  assign cycle_out = cyc_q;
  assign operand_out = operand_q;

endmodule // idx_offset_seq

`default_nettype wire

// [sim/seq_monitor.sv]
// Assertion checker for the indexed offset bus-cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_monitor (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire idx_seq_pkg::seq_req_t req_in,
  input wire logic [7:0] rdata_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire idx_seq_pkg::bus_cycle_t bus_out,
  input wire logic [2:0] cycle_out,
  input wire logic [7:0] operand_out
);
  logic tk;
  idx_seq_pkg::op_class_t c;
  idx_seq_pkg::seq_req_t r_q;
  assign tk = start_in && !busy_out;
  assign c = req_in.op_class;
  // Request held here, since the design only sees it on the taking edge
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      r_q <= '0;
    end else if (tk) begin
      r_q <= req_in;
    end
  end
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  first_fetch_a: assert property (
    tk |=> bus_out.dir && bus_out.addr == r_q.opcode_addr && cycle_out == 3'h1)
    else $error("opcode fetch wrong");
  read_len_a: assert property (
    tk && c == idx_seq_pkg::CLS_READ |-> ##2 (bus_out.addr == r_q.opcode_addr + 13'h1)[*2]
    ##1 bus_out.dir ##1 (done_out && !busy_out))
    else $error("read class timing wrong");
  store_wr_a: assert property (
    tk && c == idx_seq_pkg::CLS_STORE |-> ##2 (bus_out.addr == r_q.opcode_addr + 13'h1)[*3]
    ##1 (!bus_out.dir && bus_out.wdata == r_q.new_data) ##1 done_out)
    else $error("store wrong");
  store_ea_a: assert property (
    tk && c == idx_seq_pkg::CLS_STORE |->
    ##5 bus_out.addr == 13'(r_q.index) + 13'($past(rdata_in, 3)))
    else $error("store address wrong");
  test_next_a: assert property (
    tk && c == idx_seq_pkg::CLS_TEST |-> ##4 bus_out.dir
    ##1 (bus_out.dir && bus_out.addr == r_q.opcode_addr + 13'h2) ##1 done_out)
    else $error("test wrong");
  rmw_wr_a: assert property (
    tk && c == idx_seq_pkg::CLS_RMW |-> ##4 bus_out.dir[*2]
    ##1 (!bus_out.dir && $stable(bus_out.addr) && bus_out.wdata == r_q.new_data)
    ##1 done_out)
    else $error("rmw wrong");
  call_sub_a: assert property (
    tk && c == idx_seq_pkg::CLS_CALL |-> ##4
    (bus_out.dir && bus_out.src == idx_seq_pkg::ADR_EFFECTIVE) ##3 done_out)
    else $error("call wrong");
  call_ret_a: assert property (
    tk && c == idx_seq_pkg::CLS_CALL |-> ##5
    (!bus_out.dir && bus_out.addr == r_q.stack_ptr
      && bus_out.wdata == 8'(r_q.opcode_addr + 13'h2)) ##1
    (!bus_out.dir && bus_out.addr == r_q.stack_ptr - 13'h1
      && bus_out.wdata == 8'((r_q.opcode_addr + 13'h2) >> 8)))
    else $error("return push wrong");
  eff_addr_a: assert property (
    tk && c != idx_seq_pkg::CLS_STORE |->
    ##4 bus_out.addr == 13'(r_q.index) + 13'($past(rdata_in, 2)))
    else $error("effective addr wrong");
endmodule // seq_monitor
bind idx_offset_seq seq_monitor i_mon (.clock_in(clock_in), .rst_n_in(rst_n_in),
  .start_in(start_in), .req_in(req_in), .rdata_in(rdata_in), .busy_out(busy_out),
  .done_out(done_out), .bus_out(bus_out), .cycle_out(cycle_out), .operand_out(operand_out));
`default_nettype wire

// [sim/mem_model.sv]
// Memory and peripheral model answering the sequencer's bus cycles
`timescale 1ns/1ps
`default_nettype none
module mem_model (
  input wire idx_seq_pkg::bus_cycle_t bus_in,
  output logic [7:0] rdata_out
);
  // Write cycles: bus not driven, so show the inverse rather than a stale byte
  assign rdata_out = bus_in.dir ? (bus_in.addr[7:0] ^ 8'h5a) : ~(bus_in.addr[7:0] ^ 8'h5a);
endmodule // mem_model
`default_nettype wire

// [sim/idx_offset_seq_tb.sv]
// Self-checking bench for the indexed offset bus-cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module idx_offset_seq_tb;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic start_in = 1'b0;
  idx_seq_pkg::seq_req_t req_in = '0;
  logic [7:0] rdata_in;
  logic busy_out;
  logic done_out;
  idx_seq_pkg::bus_cycle_t bus_out;
  logic [2:0] cycle_out;
  logic [7:0] operand_out;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_clk = 0;
  logic [12:0] wa [2];
  logic [7:0] wd [2];
  int nw;
  int n;
  idx_offset_seq i_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start_in),
    .req_in(req_in), .rdata_in(rdata_in), .busy_out(busy_out), .done_out(done_out),
    .bus_out(bus_out), .cycle_out(cycle_out), .operand_out(operand_out));
  mem_model i_mem (.bus_in(bus_out), .rdata_out(rdata_in));
  initial begin
    forever #12.5 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    n_clk <= n_clk + 1;
    if (n_clk == 3000) begin
      n_mismatch++;
      finish_test();
    end
  end
  function automatic logic [7:0] mem(input logic [12:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One instruction; a stray start mid-run must be ignored
  task automatic run(input idx_seq_pkg::op_class_t cl, input logic [12:0] a,
    input logic [7:0] x, input logic [12:0] sp, input logic [7:0] nd,
    input int cyc, input bit b2b);
    if (!b2b) @(negedge clock_in);
    req_in = '{cl, a, x, sp, nd};
    start_in = 1'b1;
    @(negedge clock_in);
    start_in = 1'b0;
    nw = 0;
    for (n = 1; n < 20 && done_out !== 1'b1; n++) begin
      chk(13'(cycle_out), 13'(n));
      if (n == 1) chk(bus_out.addr, a);
      if (n == 2) start_in = 1'b1;
      if (n == 3) start_in = 1'b0;
      if (bus_out.dir === 1'b0 && nw < 2) begin
        wa[nw] = bus_out.addr;
        wd[nw] = bus_out.wdata;
        nw++;
      end
      @(negedge clock_in);
    end
    chk(13'(n), 13'(cyc + 1));
    chk(13'({busy_out, cycle_out}), 13'h0000);
  endtask
  task automatic t_read;
    run(idx_seq_pkg::CLS_READ, 13'h10a4, 8'hff, 13'h0000, 8'h00, 4, 0);
    chk(13'(operand_out), 13'(mem(13'h01fe)));
  endtask
  task automatic t_store;
    run(idx_seq_pkg::CLS_STORE, 13'h0200, 8'h10, 13'h0000, 8'h3c, 5, 1);
    chk(13'(nw), 13'h1);
    chk(wa[0], 13'h0010 + 13'(mem(13'h0201)));
    chk(13'(wd[0]), 13'h003c);
  endtask
  task automatic t_test;
    run(idx_seq_pkg::CLS_TEST, 13'h0300, 8'h22, 13'h0000, 8'h00, 5, 0);
    chk(13'(nw), 13'h0);
    chk(13'(operand_out), 13'(mem(13'h0022 + 13'(mem(13'h0301)))));
  endtask
  task automatic t_rmw;
    run(idx_seq_pkg::CLS_RMW, 13'h0400, 8'h05, 13'h0000, 8'ha7, 6, 0);
    chk(13'(nw), 13'h1);
    chk(wa[0], 13'h0005 + 13'(mem(13'h0401)));
    chk(13'(wd[0]), 13'h00a7);
  endtask
  task automatic t_call;
    run(idx_seq_pkg::CLS_CALL, 13'h1ffd, 8'h40, 13'h007f, 8'h00, 6, 0);
    chk(13'(nw), 13'h2);
    chk(wa[0], 13'h007f);
    chk(13'(wd[0]), 13'h00ff);
    chk(wa[1], 13'h007e);
    chk(13'(wd[1]), 13'h001f);
  endtask
  // Reset in mid-instruction must drop the bus back to its idle read
  task automatic t_reset;
    @(negedge clock_in);
    req_in = '{idx_seq_pkg::CLS_RMW, 13'h0500, 8'h01, 13'h0000, 8'h55};
    start_in = 1'b1;
    @(negedge clock_in);
    start_in = 1'b0;
    repeat (2) @(negedge clock_in);
    rst_n_in = 1'b0;
    @(negedge clock_in);
    chk(13'({busy_out, done_out, cycle_out}), 13'h0000);
    chk(bus_out.addr, 13'h0000);
    chk(13'(bus_out.dir), 13'h0001);
    chk(13'(operand_out), 13'h0000);
    rst_n_in = 1'b1;
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock_in);
    rst_n_in = 1'b1;
    t_read();
    t_store();
    t_test();
    t_rmw();
    t_reset();
    t_call();
    finish_test();
  end
endmodule // idx_offset_seq_tb
`default_nettype wire
